// ==== rtl/sacc_pkg.sv ====
package sacc_pkg;

    // Register addresses
    localparam logic [7:0] OPT_ADDR = 8'h94;
    localparam logic [7:0] FLG_ADDR = 8'h95;
    localparam logic [7:0] RLO_ADDR = 8'hAA;
    localparam logic [7:0] RHI_ADDR = 8'hAB;
    localparam logic [7:0] CHS_ADDR = 8'hAE;
    localparam logic [7:0] AUX_ADDR = 8'hF8;
    localparam logic [7:0] IST_ADDR = 8'hF0;
    localparam logic [7:0] IMSK_ADDR = 8'hF1;

    // Field positions
    localparam int OPT_RATE_LSB = 2;
    localparam int FLG_DONE_BIT = 4;
    localparam int AUX_START_BIT = 4;
    localparam int CHS_CH_LSB = 4;
    localparam int CHS_REF_LSB = 2;
    localparam int CHS_FORCE_BIT = 1;
    localparam int IRQ_DONE_BIT = 0;
    localparam int RES_BITS = 12;
    localparam int RHI_LSB = 4;

    // Values after reset and writable bits
    localparam logic [7:0] OPT_RST = 8'h00;
    localparam logic [7:0] CHS_RST = 8'hF0;
    localparam logic [7:0] AUX_RST = 8'h00;
    localparam logic [7:0] OPT_WMASK = 8'hBF;
    localparam logic [7:0] CHS_WMASK = 8'hFE;

    // Channel and reference codes
    localparam logic [3:0] CH_RESERVED = 4'hA;
    localparam logic [3:0] CH_BANDGAP = 4'hB;
    localparam logic [3:0] CH_QUARTER_SUPPLY = 4'hF;
    localparam logic [1:0] REF_SUPPLY = 2'h0;
    localparam logic [1:0] REF_2V5 = 2'h1;

    // Clock rate codes: last count of the divider per code
    localparam logic [1:0] RATE_DIV32 = 2'h0;
    localparam logic [1:0] RATE_DIV16 = 2'h1;
    localparam logic [1:0] RATE_DIV8 = 2'h2;
    localparam logic [1:0] RATE_DIV4 = 2'h3;
    localparam logic [4:0] DIV32_LAST = 5'h1F;
    localparam logic [4:0] DIV16_LAST = 5'h0F;
    localparam logic [4:0] DIV8_LAST = 5'h07;
    localparam logic [4:0] DIV4_LAST = 5'h03;

    // Conversion timing in converter clocks
    localparam logic [5:0] CONV_CYCLES = 6'h32;
    localparam logic [5:0] CONV_LAST = CONV_CYCLES - 6'h01;
    localparam logic [5:0] SAMPLE_CYCLES = CONV_CYCLES - 6'h18;

    typedef enum logic [0:0] {
        PH_IDLE = 1'b0,
        PH_CONV = 1'b1
    } sacc_phase_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sacc_bus_s;

    typedef struct packed {
        logic [3:0] channel;
        logic [1:0] ref_sel;
        logic bandgap_en;
        logic conv_clk;
        logic sample;
        logic busy;
    } sacc_core_s;

    typedef struct packed {
        sacc_phase_e phase;
        logic [7:0] opt;
        logic [7:0] chs;
        logic [7:0] aux;
        logic done;
        logic [11:0] result;
        logic [4:0] div_cnt;
        logic [5:0] conv_cnt;
        logic conv_clk;
        logic irq_status;
        logic irq_mask;
        logic [7:0] rdata;
    } sacc_state_s;

    localparam sacc_state_s STATE_RST = '{
        phase: PH_IDLE,
        opt: OPT_RST,
        chs: CHS_RST,
        aux: AUX_RST,
        done: 1'b0,
        result: 12'h000,
        div_cnt: 5'h00,
        conv_cnt: 6'h00,
        conv_clk: 1'b1,
        irq_status: 1'b0,
        irq_mask: 1'b0,
        rdata: 8'h00
    };

endpackage

// ==== rtl/sacc_top.sv ====
// Summary of operation
// - Converter clock is system clock divided by 32, 16, 8 or 4 per rate.
// - Writing the start bit begins conversion; hardware clears it at the end.
// - Completion sets the done flag and requests an interrupt when enabled.
// - Done flag clears by writing zero to it or one to the start bit.
// - Flag register bits clear on zero write; EFh clears only done flag.
// - Writing ones to the flag register leaves its flags unchanged.
// - One conversion lasts 50 converter clocks, sampling plus two per bit.
// - Result registers load together with the done flag setting.
// - High byte holds result 11..4, low holds 3..0 in bits 7..4.
// - Four-bit channel field routes inputs, bandgap and quarter supply.
// - Selecting the bandgap channel turns on the bandgap generator.
// - Force bit keeps bandgap on except in halt and stop modes.
// - Two-bit reference field: 00 supply, 01 2.5V, others reserved.
// - Start bit is aux bit 4, done flag is flag bit 4; reset zero.
// - Software may write zero to the start bit to clear it.
`timescale 1ns/10ps
module sacc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire sacc_pkg::sacc_bus_s bus,
    output logic [7:0] rdata,
    // Power modes from the power controller
    input wire logic halt_mode,
    input wire logic stop_mode,
    // Analog converter core
    input wire logic [11:0] core_result,
    output sacc_pkg::sacc_core_s core,
    // Interrupt
    output logic irq
);

    sacc_pkg::sacc_state_s s;
    sacc_pkg::sacc_state_s next_s;

    logic [4:0] div_last;
    logic tick;
    logic start_wr;
    logic stop_wr;
    logic [3:0] channel;

    assign channel = s.chs[sacc_pkg::CHS_CH_LSB +: 4];

    always_comb begin
        unique case (s.opt[sacc_pkg::OPT_RATE_LSB +: 2])
            sacc_pkg::RATE_DIV32: div_last = sacc_pkg::DIV32_LAST;
            sacc_pkg::RATE_DIV16: div_last = sacc_pkg::DIV16_LAST;
            sacc_pkg::RATE_DIV8: div_last = sacc_pkg::DIV8_LAST;
            sacc_pkg::RATE_DIV4: div_last = sacc_pkg::DIV4_LAST;
        endcase
    end

    assign tick = (s.div_cnt == div_last);
    assign start_wr = bus.wr && (bus.addr == sacc_pkg::AUX_ADDR)
        && bus.wdata[sacc_pkg::AUX_START_BIT];
    assign stop_wr = bus.wr && (bus.addr == sacc_pkg::AUX_ADDR)
        && !bus.wdata[sacc_pkg::AUX_START_BIT];

    always_comb begin
        next_s = s;

        // Read data for the cycle after the strobe
        next_s.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                sacc_pkg::OPT_ADDR: next_s.rdata = s.opt;
                sacc_pkg::FLG_ADDR:
                    next_s.rdata[sacc_pkg::FLG_DONE_BIT] = s.done;
                sacc_pkg::RLO_ADDR:
                    next_s.rdata = {s.result[3:0], 4'h0};
                sacc_pkg::RHI_ADDR:
                    next_s.rdata = s.result[sacc_pkg::RHI_LSB +: 8];
                sacc_pkg::CHS_ADDR: next_s.rdata = s.chs;
                sacc_pkg::AUX_ADDR: next_s.rdata = s.aux;
                sacc_pkg::IST_ADDR:
                    next_s.rdata[sacc_pkg::IRQ_DONE_BIT] = s.irq_status;
                sacc_pkg::IMSK_ADDR:
                    next_s.rdata[sacc_pkg::IRQ_DONE_BIT] = s.irq_mask;
                default: next_s.rdata = 8'h00;
            endcase
            if (bus.addr == sacc_pkg::IST_ADDR) begin
                next_s.irq_status = 1'b0;
            end
        end

        // Register writes; result registers ignore writes
        if (bus.wr) begin
            case (bus.addr)
                sacc_pkg::OPT_ADDR:
                    next_s.opt = bus.wdata & sacc_pkg::OPT_WMASK;
                sacc_pkg::CHS_ADDR:
                    next_s.chs = bus.wdata & sacc_pkg::CHS_WMASK;
                sacc_pkg::FLG_ADDR: begin
                    // Zero clears, one keeps
                    if (!bus.wdata[sacc_pkg::FLG_DONE_BIT]) begin
                        next_s.done = 1'b0;
                    end
                end
                sacc_pkg::AUX_ADDR: next_s.aux = bus.wdata;
                sacc_pkg::IMSK_ADDR:
                    next_s.irq_mask = bus.wdata[sacc_pkg::IRQ_DONE_BIT];
                default: ;
            endcase
        end

        // Converter clock divider
        if (tick) begin
            next_s.div_cnt = 5'h00;
        end else begin
            next_s.div_cnt = s.div_cnt + 5'h01;
        end

        unique case (s.phase)
            sacc_pkg::PH_IDLE: begin
                if (start_wr) begin
                    next_s.phase = sacc_pkg::PH_CONV;
                    next_s.conv_cnt = 6'h00;
                    next_s.div_cnt = 5'h00;
                    next_s.done = 1'b0;
                end
            end
            sacc_pkg::PH_CONV: begin
                if (start_wr) begin
                    // Restart drops the running conversion
                    next_s.conv_cnt = 6'h00;
                    next_s.div_cnt = 5'h00;
                    next_s.done = 1'b0;
                end else if (stop_wr) begin
                    next_s.phase = sacc_pkg::PH_IDLE;
                    next_s.conv_cnt = 6'h00;
                end else if (tick) begin
                    if (s.conv_cnt == sacc_pkg::CONV_LAST) begin
                        next_s.phase = sacc_pkg::PH_IDLE;
                        next_s.conv_cnt = 6'h00;
                        next_s.result = core_result;
                        next_s.done = 1'b1;
                        next_s.irq_status = 1'b1;
                        next_s.aux[sacc_pkg::AUX_START_BIT] = 1'b0;
                    end else begin
                        next_s.conv_cnt = s.conv_cnt + 6'h01;
                    end
                end
            end
        endcase

        // High during the first half of each converter clock
        next_s.conv_clk = (next_s.div_cnt <= (div_last >> 1));
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= sacc_pkg::STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        core.channel = channel;
        core.ref_sel = s.chs[sacc_pkg::CHS_REF_LSB +: 2];
        core.bandgap_en = (channel == sacc_pkg::CH_BANDGAP)
            || (s.chs[sacc_pkg::CHS_FORCE_BIT]
            && !(halt_mode || stop_mode));
        core.conv_clk = s.conv_clk;
        core.busy = (s.phase == sacc_pkg::PH_CONV);
        core.sample = (s.phase == sacc_pkg::PH_CONV)
            && (s.conv_cnt < sacc_pkg::SAMPLE_CYCLES);
    end

    assign rdata = s.rdata;
    assign irq = s.irq_status && s.irq_mask;

endmodule

// ==== verif/sacc_core_model.sv ====
`timescale 1ns/10ps
module sacc_core_model (
    // Converter core controls
    input wire sacc_pkg::sacc_core_s core,
    // Result word
    output logic [11:0] core_result
);
    // Word follows the channel; inverted outside a conversion
    assign core_result = core.busy ? {core.channel, 8'h5A}
                                   : ~{core.channel, 8'h5A};
endmodule

// ==== verif/sacc_chk.sv ====
`timescale 1ns/10ps
module sacc_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched ports
    input wire sacc_pkg::sacc_bus_s bus,
    input wire logic [7:0] rdata,
    input wire logic halt_mode,
    input wire logic stop_mode,
    input wire logic [11:0] core_result,
    input wire sacc_pkg::sacc_core_s core,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire aux_wr = bus.wr && bus.addr == sacc_pkg::AUX_ADDR;
    wire chs_wr = bus.wr && bus.addr == sacc_pkg::CHS_ADDR;
    wire msk_wr = bus.wr && bus.addr == sacc_pkg::IMSK_ADDR;
    property p_bg;
        core.channel == sacc_pkg::CH_BANDGAP |-> core.bandgap_en; endproperty
    a_bg: assert property (p_bg) else $error("bandgap off");
    property p_pwr; (halt_mode || stop_mode) &&
        core.channel != sacc_pkg::CH_BANDGAP |-> !core.bandgap_en; endproperty
    a_pwr: assert property (p_pwr) else $error("bandgap on");
    property p_go;
        aux_wr && bus.wdata[4] |=> core.busy && core.sample; endproperty
    a_go: assert property (p_go) else $error("no start");
    property p_stop;
        aux_wr && !bus.wdata[4] |=> !core.busy; endproperty
    a_stop: assert property (p_stop) else $error("no abort");
    property p_lo;
        bus.rd && bus.addr == sacc_pkg::RLO_ADDR |=> rdata[3:0] == 4'h0;
    endproperty
    a_lo: assert property (p_lo) else $error("low nibble");
    property p_cfg;
        chs_wr |=> {core.channel, core.ref_sel} == $past(bus.wdata[7:2]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("channel");
    property p_hold;
        !chs_wr |=> $stable({core.channel, core.ref_sel}); endproperty
    a_hold: assert property (p_hold) else $error("ref moved");
    property p_idle; !bus.rd |=> rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data");
    property p_irq; $rose(irq) |-> $fell(core.busy) || $past(msk_wr);
    endproperty
    a_irq: assert property (p_irq) else $error("stray irq");
endmodule
bind sacc_top sacc_chk i_chk (.clk(clk), .srst(srst), .bus(bus),
    .rdata(rdata), .halt_mode(halt_mode), .stop_mode(stop_mode),
    .core_result(core_result), .core(core), .irq(irq));

// ==== verif/sar_adc_conversion_control_tb_top.sv ====
`timescale 1ns/10ps
module sar_adc_conversion_control_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic halt_mode = 1'b0;
    logic stop_mode = 1'b0;
    sacc_pkg::sacc_bus_s bus = '0;
    logic [7:0] rdata;
    logic [11:0] core_result;
    sacc_pkg::sacc_core_s core;
    logic irq;
    logic [3:0] ch;
    int n_fail = 0;
    int checks = 0;
    int n;
    always #20 clk = ~clk;
    sacc_top i_dut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
        .halt_mode(halt_mode), .stop_mode(stop_mode),
        .core_result(core_result), .core(core), .irq(irq));
    sacc_core_model i_core (.core(core), .core_result(core_result));
    task automatic chk(input string nm, input logic [11:0] e, a);
        checks++;
        if (a !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, a);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, e, input string nm);
        @(posedge clk);
        bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk(nm, {4'h0, e}, {4'h0, rdata});
    endtask
    task automatic conv(input int exp);
        logic last;
        int rises;
        n = 0;
        rises = 0;
        last = core.conv_clk;
        while (core.busy === 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
            if (core.conv_clk === 1'b1 && last === 1'b0) begin
                rises++;
            end
            last = core.conv_clk;
        end
        chk("conversion length", 12'(exp), 12'(n));
        chk("converter clocks", 12'(sacc_pkg::CONV_CYCLES),
            12'(rises));
    endtask
    task automatic finish_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #800000;
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rd(sacc_pkg::CHS_ADDR, 8'hF0, "channel reg");
        rd(sacc_pkg::AUX_ADDR, 8'h00, "aux reg");
        rd(sacc_pkg::FLG_ADDR, 8'h00, "flag reg");
        rd(8'h00, 8'h00, "unmapped");
        $display("test reset done");
        for (int r = 0; r < 4; r++) begin
            ch = 4'hB + 4'(r);
            wr(sacc_pkg::OPT_ADDR, 8'(r << 2));
            wr(sacc_pkg::CHS_ADDR, {ch, 4'h0});
            chk("bandgap", 12'(r == 0), 12'(core.bandgap_en));
            wr(sacc_pkg::IMSK_ADDR, 8'(r & 1));
            wr(sacc_pkg::AUX_ADDR, 8'h10);
            conv(50 * (32 >> r));
            chk("irq", 12'(r & 1), 12'(irq));
            rd(sacc_pkg::AUX_ADDR, 8'h00, "start bit");
            rd(sacc_pkg::FLG_ADDR, 8'h10, "done flag");
            wr(sacc_pkg::RHI_ADDR, 8'h00);
            rd(sacc_pkg::RHI_ADDR, {ch, 4'h5}, "result high");
            rd(sacc_pkg::RLO_ADDR, 8'hA0, "result low");
            rd(sacc_pkg::IST_ADDR, 8'h01, "irq status");
            chk("irq clear", 12'h000, 12'(irq));
            wr(sacc_pkg::FLG_ADDR, 8'hFF);
            rd(sacc_pkg::FLG_ADDR, 8'h10, "flag kept");
            wr(sacc_pkg::FLG_ADDR, 8'hEF);
            rd(sacc_pkg::FLG_ADDR, 8'h00, "flag clear");
        end
        $display("test rates done");
        wr(sacc_pkg::OPT_ADDR, 8'h00);
        wr(sacc_pkg::AUX_ADDR, 8'h10);
        conv(50 * 32);
        wr(sacc_pkg::AUX_ADDR, 8'h10);
        rd(sacc_pkg::FLG_ADDR, 8'h00, "done on start");
        repeat (20) @(posedge clk);
        wr(sacc_pkg::AUX_ADDR, 8'h10);
        conv(50 * 32);
        wr(sacc_pkg::AUX_ADDR, 8'h10);
        wr(sacc_pkg::AUX_ADDR, 8'h00);
        repeat (1700) @(posedge clk);
        rd(sacc_pkg::FLG_ADDR, 8'h00, "abort flag");
        chk("abort busy", 12'h000, 12'(core.busy));
        $display("test restart done");
        wr(sacc_pkg::CHS_ADDR, 8'hF6);
        chk("ref", 12'h03D, {6'h00, core.channel, core.ref_sel});
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            halt_mode <= (m == 1);
            stop_mode <= (m == 2);
            @(posedge clk);
            #1;
            chk("forced bandgap", 12'(m == 0), 12'(core.bandgap_en));
        end
        $display("test power done");
        finish_test();
    end
endmodule
